// ==== hw/sbsr_err_latch.sv ====
// Sticky error word and the latched error flag
// Assumes one-cycle error pulses and a clear mask from a word read
module sbsr_err_latch
  import sbsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sbsr_err_if.latch e
);
  logic [SBSR_EW_W-1:0] word_r;
  logic [SBSR_EW_W-1:0] word_nxt;
  logic flag_r;
  logic flag_nxt;

  // ------------------------------------------------------------------
  // Latch
  // ------------------------------------------------------------------
  always_comb begin
    word_nxt = (word_r & ~e.clr) | e.src;
    flag_nxt = |word_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= SBSR_EW_RST;
      flag_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign e.word = word_r;
  assign e.flag = flag_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_err_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    |e.src |=> flag_r)
    else $error("error source lost");
  a_err_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    flag_r && e.clr == SBSR_EW_RST && e.src == SBSR_EW_RST |=> flag_r)
    else $error("error flag dropped without clear");
endmodule

// ==== hw/sbsr_top.sv ====
// Status byte, service request mask and error flag with APB registers
// Assumes synchronous condition inputs and one-cycle error pulses
//
// Behaviour
// - Illegal command or illegal command option sets the error condition.
// - Programming while not in remote sets the error condition.
// - Trigger arriving while a reading is in progress sets the error condition.
// - Calibration value out of limits sets the error condition.
// - Mask bit five (32) makes an error assert service request while error requests are armed.
// - Error word query clears error bit and re-arms error requests.
// - Controller polls status byte after request; the poll releases the line.
// - Status byte frozen when a request is generated.
// - Request flag bit six cleared by a status byte read.
// - Status byte stays readable with all requests disabled.
// - Without pending request bits 0, 1, 3, 4 track live conditions.
// - Error bit latches without a request until the error word is read.
// - Mask value 3 enables overflow and store-full requests.
// - Mask value 40 enables reading-done and error requests.
// - Mask is sum of weights 1, 2, 8, 16, 32; several at once.
// - Power-up and device clear reset the mask to zero.
// - Status bits two and seven always read zero.
module sbsr_top
  import sbsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SBSR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic illegal_command_error,
  input wire logic illegal_option_error,
  input wire logic prog_not_remote,
  input wire logic trigger_in,
  input wire logic reading_busy,
  input wire logic cal_out_of_limits,
  input wire logic cond_overflow,
  input wire logic cond_store_full,
  input wire logic cond_reading_done,
  input wire logic cond_ready,
  output logic srq,
  output logic irq
);
  // ------------------------------------------------------------------
  // Error word latch
  // ------------------------------------------------------------------
  sbsr_err_if eif ();
  logic [SBSR_EW_W-1:0] ew_clr;

  assign eif.src[EW_ILLEGAL] = illegal_command_error | illegal_option_error;
  assign eif.src[EW_NOT_REMOTE] = prog_not_remote;
  assign eif.src[EW_OVERRUN] = trigger_in & reading_busy;
  assign eif.src[EW_CAL] = cal_out_of_limits;
  assign eif.clr = ew_clr;

  sbsr_err_latch u_err (
    .pclk(pclk),
    .presetn(presetn),
    .e(eif.latch)
  );

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] frozen_r, frozen_nxt;
  logic rqs_r, rqs_nxt;
  logic armed_r, armed_nxt;
  logic flag_d_r, flag_d_nxt;
  logic [SBSR_IRQ_W-1:0] isr_r, isr_nxt;
  logic [SBSR_IRQ_W-1:0] imr_r, imr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic srq_r, irq_r;
  logic [7:0] live;
  logic [7:0] req_src;
  logic [7:0] poll_byte;
  logic setup, acc, wr_acc, rd_acc, mapped, fire, poll_clr, query, dev_clr;

  // ------------------------------------------------------------------
  // Status byte and request
  // ------------------------------------------------------------------
  always_comb begin
    live = SBSR_BYTE_ZERO;
    live[SB_OVF] = cond_overflow;
    live[SB_FULL] = cond_store_full;
    live[SB_DONE] = cond_reading_done;
    live[SB_RDY] = cond_ready;
    live[SB_ERR] = eif.flag;
    req_src = live;
    req_src[SB_ERR] = eif.flag & armed_r;
    poll_byte = rqs_r ? frozen_r : live;
  end

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  always_comb begin
    setup = psel & ~penable;
    acc = psel & penable & pready_r;
    wr_acc = acc & pwrite;
    rd_acc = acc & ~pwrite;
    mapped = (paddr == SBSR_OFF_MASK) || (paddr == SBSR_OFF_POLL) ||
      (paddr == SBSR_OFF_ERRW) || (paddr == SBSR_OFF_ISR) ||
      (paddr == SBSR_OFF_IMR) || (paddr == SBSR_OFF_CMD);
    poll_clr = rd_acc && paddr == SBSR_OFF_POLL && prdata_r[SB_RQS];
    query = rd_acc && paddr == SBSR_OFF_ERRW;
    ew_clr = query ? prdata_r[SBSR_EW_W-1:0] : SBSR_EW_RST;
    dev_clr = wr_acc && paddr == SBSR_OFF_CMD && pwdata[CMD_DEV_CLEAR];
    fire = ~rqs_r & |(req_src & mask_r);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    mask_nxt = mask_r;
    frozen_nxt = frozen_r;
    rqs_nxt = rqs_r;
    armed_nxt = armed_r;
    flag_d_nxt = eif.flag;
    isr_nxt = isr_r;
    imr_nxt = imr_r;
    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt = prdata_r;
    if (wr_acc && paddr == SBSR_OFF_MASK) begin
      mask_nxt = pwdata[7:0] & SBSR_MASK_VALID;
    end
    if (dev_clr) begin
      mask_nxt = SBSR_MASK_RST;
    end
    if (wr_acc && paddr == SBSR_OFF_IMR) begin
      imr_nxt = pwdata[SBSR_IRQ_W-1:0];
    end
    if (wr_acc && paddr == SBSR_OFF_ISR) begin
      isr_nxt = isr_r & ~pwdata[SBSR_IRQ_W-1:0];
    end
    if (query) begin
      armed_nxt = 1'b1;
    end
    if (poll_clr) begin
      rqs_nxt = 1'b0;
    end
    if (fire) begin
      rqs_nxt = 1'b1;
      frozen_nxt = live;
      frozen_nxt[SB_RQS] = 1'b1;
      if (req_src[SB_ERR] & mask_r[SB_ERR]) begin
        armed_nxt = 1'b0;
      end
      isr_nxt[IRQ_SRQ] = 1'b1;
    end
    if (eif.flag & ~flag_d_r) begin
      isr_nxt[IRQ_ERR] = 1'b1;
    end
    if (setup) begin
      prdata_nxt = SBSR_DATA_ZERO;
      if (!pwrite) begin
        case (paddr)
          SBSR_OFF_MASK: prdata_nxt[7:0] = mask_r;
          SBSR_OFF_POLL: prdata_nxt[7:0] = poll_byte;
          SBSR_OFF_ERRW: prdata_nxt[SBSR_EW_W-1:0] = eif.word;
          SBSR_OFF_ISR: prdata_nxt[SBSR_IRQ_W-1:0] = isr_r;
          SBSR_OFF_IMR: prdata_nxt[SBSR_IRQ_W-1:0] = imr_r;
          default: prdata_nxt = SBSR_DATA_ZERO;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= SBSR_MASK_RST;
      frozen_r <= SBSR_BYTE_ZERO;
      rqs_r <= 1'b0;
      armed_r <= 1'b1;
      flag_d_r <= 1'b0;
      isr_r <= SBSR_IRQ_RST;
      imr_r <= SBSR_IRQ_RST;
      prdata_r <= SBSR_DATA_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      srq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      frozen_r <= frozen_nxt;
      rqs_r <= rqs_nxt;
      armed_r <= armed_nxt;
      flag_d_r <= flag_d_nxt;
      isr_r <= isr_nxt;
      imr_r <= imr_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      srq_r <= rqs_nxt;
      irq_r <= |(isr_nxt & imr_nxt);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign srq = srq_r;
  assign irq = irq_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_mask_fires: assert property (
    !rqs_r && mask_r[SB_ERR] && eif.flag && armed_r |=> srq && rqs_r)
    else $error("error with mask 32 did not raise request");
  a_query_rearms: assert property (query |=> armed_r)
    else $error("error query did not re-arm");
  a_poll_release: assert property (poll_clr && !fire |=> !srq ##0 !rqs_r)
    else $error("poll did not release request line");
  a_frozen_byte: assert property (rqs_r && !poll_clr |=> $stable(frozen_r))
    else $error("pending status byte changed");
  a_rqs_bit_clear: assert property (
    rd_acc && paddr == SBSR_OFF_POLL && prdata_r[SB_RQS] |=> !frozen_r[SB_RQS] || !rqs_r)
    else $error("request flag not cleared by poll");
  a_live_tracking: assert property (
    setup && !pwrite && paddr == SBSR_OFF_POLL && !rqs_r |=>
      prdata_r[SB_RDY] == $past(cond_ready) && prdata_r[SB_OVF] == $past(cond_overflow))
    else $error("live status bits not tracked");
  a_mask_bits_only: assert property (
    wr_acc && paddr == SBSR_OFF_MASK && !dev_clr |=> mask_r == ($past(pwdata[7:0]) & SBSR_MASK_VALID))
    else $error("mask write not stored");
  a_dev_clear_mask: assert property (dev_clr |=> mask_r == SBSR_MASK_RST)
    else $error("device clear left mask set");
  a_unused_bits_zero: assert property (
    pready && paddr == SBSR_OFF_POLL && !pwrite |->
      !prdata[SB_SPARE_LO] && !prdata[SB_SPARE_HI])
    else $error("unused status bits read nonzero");
  a_srq_on_cond: assert property (
    !rqs_r && mask_r[SB_OVF] && cond_overflow |=> srq)
    else $error("overflow with mask did not raise request");
  a_overrun_err: assert property (trigger_in && reading_busy |=> eif.flag)
    else $error("trigger overrun not flagged");

  // ------------------------------------------------------------------
  // Error source checks
  // ------------------------------------------------------------------
  a_illegal_err: assert property (
    illegal_command_error || illegal_option_error |=> eif.word[EW_ILLEGAL])
    else $error("illegal command not flagged");
  a_remote_err: assert property (
    prog_not_remote |=> eif.word[EW_NOT_REMOTE])
    else $error("programming outside remote not flagged");
  a_cal_err: assert property (
    cal_out_of_limits |=> eif.word[EW_CAL])
    else $error("calibration limit error not flagged");
  a_err_bit_latch: assert property (
    setup && !pwrite && paddr == SBSR_OFF_POLL && !rqs_r && eif.flag |=> prdata_r[SB_ERR])
    else $error("latched error bit missing from poll");
  a_query_clears: assert property (query && eif.src == SBSR_EW_RST |=>
    (eif.word & $past(prdata_r[SBSR_EW_W-1:0])) == SBSR_EW_RST)
    else $error("error query left returned bits set");
  a_isr_err_rise: assert property (eif.flag && !flag_d_r |=> isr_r[IRQ_ERR])
    else $error("error rise not recorded");

  // ------------------------------------------------------------------
  // Request, poll and unmapped access checks
  // ------------------------------------------------------------------
  a_full_req: assert property (
    !rqs_r && mask_r[SB_FULL] && cond_store_full |=> srq)
    else $error("store full with mask did not raise request");
  a_done_req: assert property (
    !rqs_r && mask_r[SB_DONE] && cond_reading_done |=> srq)
    else $error("reading done with mask did not raise request");
  a_disabled_poll: assert property (
    setup && !pwrite && paddr == SBSR_OFF_POLL && !rqs_r && mask_r == SBSR_MASK_RST |=>
      prdata_r[7:0] == $past(live))
    else $error("status byte unreadable with requests disabled");
  a_flag_in_byte: assert property (rqs_r |-> frozen_r[SB_RQS])
    else $error("pending byte lacks request flag");
  a_req_has_cause: assert property ($rose(rqs_r) |-> $past(|(req_src & mask_r)))
    else $error("request raised without enabled cause");
  a_spare_frozen: assert property (
    rqs_r |-> !frozen_r[SB_SPARE_LO] && !frozen_r[SB_SPARE_HI])
    else $error("unused bits set in pending byte");
  a_unmapped_err: assert property (setup && !mapped |=> pready && pslverr)
    else $error("unmapped access not refused");

  // ------------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------------
  c_error_srq: cover property (fire && req_src[SB_ERR]);
  c_poll_release: cover property (poll_clr);
  c_query_clear: cover property (query && eif.flag);
  c_disabled_read: cover property (rd_acc && paddr == SBSR_OFF_POLL && mask_r == SBSR_MASK_RST);
  c_mask_pair: cover property (fire && mask_r[SB_DONE] && mask_r[SB_ERR]);
endmodule

// ==== include/sbsr_err_if.sv ====
// Bundle between the status logic and the error word latch
// Assumes both ends share pclk and presetn
interface sbsr_err_if;
  import sbsr_pkg::*;
  logic [SBSR_EW_W-1:0] src;
  logic [SBSR_EW_W-1:0] clr;
  logic [SBSR_EW_W-1:0] word;
  logic flag;
  modport latch (input src, input clr, output word, output flag);
  modport user (output src, output clr, input word, input flag);
endinterface

// ==== include/sbsr_pkg.sv ====
// Constants for the status byte and service request block
// Assumes a 32-bit APB register bus on one 200 MHz clock
package sbsr_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int SBSR_AW = 8;
  localparam logic [7:0] SBSR_OFF_MASK = 8'h00;
  localparam logic [7:0] SBSR_OFF_POLL = 8'h04;
  localparam logic [7:0] SBSR_OFF_ERRW = 8'h08;
  localparam logic [7:0] SBSR_OFF_ISR = 8'h0C;
  localparam logic [7:0] SBSR_OFF_IMR = 8'h10;
  localparam logic [7:0] SBSR_OFF_CMD = 8'h14;
  // ------------------------------------------------------------------
  // Status byte and mask fields
  // ------------------------------------------------------------------
  localparam int SB_OVF = 0;
  localparam int SB_FULL = 1;
  localparam int SB_DONE = 3;
  localparam int SB_RDY = 4;
  localparam int SB_ERR = 5;
  localparam int SB_RQS = 6;
  localparam int SB_SPARE_LO = 2;
  localparam int SB_SPARE_HI = 7;
  localparam logic [7:0] SBSR_MASK_VALID = 8'h3B;
  localparam logic [7:0] SBSR_MASK_RST = 8'h00;
  localparam logic [7:0] SBSR_BYTE_ZERO = 8'h00;
  // ------------------------------------------------------------------
  // Error word, interrupt and command fields
  // ------------------------------------------------------------------
  localparam int EW_ILLEGAL = 0;
  localparam int EW_NOT_REMOTE = 1;
  localparam int EW_OVERRUN = 2;
  localparam int EW_CAL = 3;
  localparam int SBSR_EW_W = 4;
  localparam logic [SBSR_EW_W-1:0] SBSR_EW_RST = 4'h0;
  localparam int IRQ_SRQ = 0;
  localparam int IRQ_ERR = 1;
  localparam int SBSR_IRQ_W = 2;
  localparam logic [SBSR_IRQ_W-1:0] SBSR_IRQ_RST = 2'h0;
  localparam int CMD_DEV_CLEAR = 0;
  localparam logic [31:0] SBSR_DATA_ZERO = 32'h0000_0000;
endpackage

// ==== verification/sbsr_ctrl_model.sv ====
// Bus controller model: APB master for mask writes and serial polls
// Assumes pclk from the bench and any number of access cycles
module sbsr_ctrl_model
  import sbsr_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [SBSR_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Setup, access until pready, then release; a poll is a read of the status byte
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// ==== verification/tb_status_byte_service_request.sv ====
// Self-checking bench for the status byte and service request block
// Assumes the controller model drives APB and the bench drives conditions
module tb_status_byte_service_request;
  import sbsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, srq, irq, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] cnd;
  logic [5:0] ev;
  int failures, n_tests;
  always #2.5 pclk = ~pclk;
  sbsr_ctrl_model u_ctrl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sbsr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .illegal_command_error(ev[0]), .illegal_option_error(ev[1]),
    .prog_not_remote(ev[2]), .trigger_in(ev[3]), .reading_busy(ev[4]),
    .cal_out_of_limits(ev[5]), .cond_overflow(cnd[0]), .cond_store_full(cnd[1]),
    .cond_reading_done(cnd[2]), .cond_ready(cnd[3]), .srq(srq), .irq(irq));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ctrl.xfer(1'b1, a, d, rv, re);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ctrl.xfer(1'b0, a, 32'h0000_0000, rv, re);
  endtask
  task automatic pulse(input logic [5:0] p);
    @(posedge pclk);
    ev <= p;
    @(posedge pclk);
    ev <= 6'h00;
  endtask
  task automatic wsrq();
    int n;
    n = 0;
    while (srq !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_track();
    rd(SBSR_OFF_MASK);
    chk("mask reset", rv, 32'h0000_0000);
    cnd <= 4'hF;
    rd(SBSR_OFF_POLL);
    chk("poll all", rv, 32'h0000_001B);
    chk("srq off", 32'(srq), 32'h0000_0000);
    cnd <= 4'h5;
    rd(SBSR_OFF_POLL);
    chk("poll some", rv, 32'h0000_0009);
    cnd <= 4'h0;
    $display("test track done");
  endtask
  task automatic t_req();
    logic [7:0] mk [4] = '{8'h03, 8'h03, 8'h28, 8'h10};
    logic [7:0] sb [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
    for (int i = 0; i < 4; i++) begin
      wr(SBSR_OFF_MASK, {24'h00_0000, mk[i]});
      cnd[i] <= 1'b1;
      wsrq();
      chk("srq up", 32'(srq), 32'h0000_0001);
      cnd[i] <= 1'b0;
      rd(SBSR_OFF_POLL);
      chk("frozen", rv, {24'h00_0000, sb[i] | 8'h40});
      repeat (2) @(posedge pclk);
      chk("srq down", 32'(srq), 32'h0000_0000);
      rd(SBSR_OFF_POLL);
      chk("rqs clear", rv, 32'h0000_0000);
    end
    $display("test request done");
  endtask
  task automatic t_err();
    logic [5:0] ep [6] = '{6'h01, 6'h02, 6'h04, 6'h18, 6'h20, 6'h08};
    logic [3:0] ew [6] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    wr(SBSR_OFF_MASK, 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      pulse(ep[k]);
      rd(SBSR_OFF_POLL);
      chk("err bit", rv, (ew[k] != 4'h0) ? 32'h0000_0020 : 32'h0000_0000);
      chk("srq off", 32'(srq), 32'h0000_0000);
      rd(SBSR_OFF_ERRW);
      chk("err word", rv, {28'h000_0000, ew[k]});
      rd(SBSR_OFF_POLL);
      chk("err clear", rv, 32'h0000_0000);
    end
    $display("test error done");
  endtask
  task automatic t_err_srq();
    wr(SBSR_OFF_MASK, 32'h0000_0020);
    pulse(6'h01);
    wsrq();
    chk("srq err", 32'(srq), 32'h0000_0001);
    rd(SBSR_OFF_POLL);
    chk("err poll", rv, 32'h0000_0060);
    pulse(6'h20);
    repeat (4) @(posedge pclk);
    chk("disarmed", 32'(srq), 32'h0000_0000);
    rd(SBSR_OFF_ERRW);
    chk("err word", rv, 32'h0000_0009);
    pulse(6'h04);
    wsrq();
    chk("rearmed", 32'(srq), 32'h0000_0001);
    rd(SBSR_OFF_POLL);
    rd(SBSR_OFF_ERRW);
    chk("err word", rv, 32'h0000_0002);
    $display("test error request done");
  endtask
  task automatic t_irq();
    wr(SBSR_OFF_ISR, 32'h0000_0003);
    wr(SBSR_OFF_IMR, 32'h0000_0001);
    wr(SBSR_OFF_MASK, 32'h0000_0010);
    cnd[3] <= 1'b1;
    wsrq();
    rd(SBSR_OFF_ISR);
    chk("isr", rv, 32'h0000_0001);
    chk("irq on", 32'(irq), 32'h0000_0001);
    wr(SBSR_OFF_IMR, 32'h0000_0000);
    @(posedge pclk);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(SBSR_OFF_IMR, 32'h0000_0001);
    wr(SBSR_OFF_ISR, 32'h0000_0001);
    @(posedge pclk);
    chk("irq clear", 32'(irq), 32'h0000_0000);
    cnd[3] <= 1'b0;
    rd(SBSR_OFF_POLL);
    chk("ready poll", rv, 32'h0000_0050);
    wr(SBSR_OFF_IMR, 32'h0000_0002);
    pulse(6'h20);
    repeat (2) @(posedge pclk);
    chk("irq err", 32'(irq), 32'h0000_0001);
    rd(SBSR_OFF_ERRW);
    chk("cal word", rv, 32'h0000_0008);
    wr(SBSR_OFF_ISR, 32'h0000_0003);
    $display("test interrupt done");
  endtask
  task automatic t_clr();
    wr(SBSR_OFF_MASK, 32'h0000_00FF);
    rd(SBSR_OFF_MASK);
    chk("mask all", rv, 32'h0000_003B);
    wr(SBSR_OFF_CMD, 32'h0000_0001);
    rd(SBSR_OFF_MASK);
    chk("dev clear", rv, 32'h0000_0000);
    rd(8'h20);
    chk("unmapped err", 32'(re), 32'h0000_0001);
    chk("unmapped data", rv, 32'h0000_0000);
    $display("test clear done");
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    cnd = 4'h0;
    ev = 6'h00;
    failures = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_track();
    t_req();
    t_err();
    t_err_srq();
    t_irq();
    t_clr();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict();
  end
endmodule
